// *** rtl/fifo_cfg_pkg.sv ***
package fifo_cfg_pkg;
    localparam logic [7:0] probe_ofs = 8'h64;
    localparam logic [7:0] thresh_ofs = 8'h68;
    localparam logic [7:0] rxcfg_ofs = 8'h6c;
    localparam logic [7:0] int_sts_ofs = 8'h58;
    localparam logic [7:0] int_en_ofs = 8'h5c;
    localparam logic [7:0] rxread_ofs = 8'h00;
    localparam logic [31:0] probe_value = 32'h87654321;
    localparam int tx_space_lsb = 24;
    localparam int tx_stat_lsb = 16;
    localparam int rx_stat_lsb = 0;
    localparam logic [7:0] tx_space_rst = 8'h48;
    localparam logic [7:0] tx_stat_rst = 8'h00;
    localparam logic [7:0] rx_stat_rst = 8'h00;
    localparam int align_lsb = 30;
    localparam int countdown_lsb = 16;
    localparam int flush_bit = 15;
    localparam int offset_lsb = 8;
    localparam int sts_rx_level = 3;
    localparam int sts_tx_level = 7;
    localparam int sts_tx_space = 9;
    localparam int sts_rx_dma = 20;
    localparam logic [31:0] sts_mask = 32'h00100288;
endpackage

// *** rtl/fifo_level_config.sv ***
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Probe register reads fixed constant pattern.
// - TX space above threshold raises event.
// - TX status used above threshold raises event.
// - RX status used above threshold raises event.
// - Pad DWORDs after packet to alignment.
// - Alignment codes 4, 16, 32 bytes.
// - Countdown decrements per RX FIFO pop, interrupts.
// - Countdown write replaces count anytime.
// - Flush bit clears RX pointers, self-clears.
// - Start offset bytes precede packet data.
// - Upper offset bits apply next read.
// - Probe write wakes from reduced power.
// - Countdown interrupt enabled by bit 20.
// - TX status level latched bit 7.
module fifo_level_config #(
    parameter int cnt_w = 12
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [7:0] tx_free_blocks_i,
    input wire logic [7:0] tx_status_used_i,
    input wire logic [7:0] rx_status_used_i,
    input wire logic [cnt_w-1:0] pkt_dwords_i,
    input wire logic [31:0] rx_fifo_data_i,
    input wire logic sleeping_i,
    output logic rx_fifo_pop_o,
    output logic rx_flush_o,
    output logic wake_o,
    output logic rx_last_o,
    output logic irq_o
);
    typedef struct packed {
        logic [7:0] tx_space_lvl;
        logic [7:0] tx_stat_lvl;
        logic [7:0] rx_stat_lvl;
        logic [1:0] align;
        logic [cnt_w-1:0] countdown;
        logic armed;
        logic [4:0] offset;
        logic flush;
        logic wake;
        logic [31:0] sts;
        logic [31:0] en;
        logic [31:0] rdata;
        logic port_rd;
    } regs_t;
    regs_t cur_ff;
    regs_t nxt_ff;
    logic rd_data;
    logic pop;
    logic [31:0] fmt_data;
    logic [31:0] ev;

    function automatic logic hit(input logic [7:0] a);
        hit = (addr_i == a);
    endfunction

    assign rd_data = rd_i && hit(fifo_cfg_pkg::rxread_ofs);

    rx_read_formatter #(
        .dw_cnt_w(cnt_w)
    ) u_fmt (
        .core_clk_i(core_clk_i),
        // A flush also drops a partly read packet, so the formatter restarts.
        .srst_i(srst_i || cur_ff.flush),
        .read_i(rd_data),
        .align_i(cur_ff.align),
        .offset_i(cur_ff.offset),
        .pkt_dwords_i(pkt_dwords_i),
        .fifo_data_i(rx_fifo_data_i),
        .fifo_pop_o(pop),
        .data_o(fmt_data),
        .last_o(rx_last_o)
    );

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.flush = 1'b0;
        nxt_ff.wake = 1'b0;
        ev = 32'h0;
        ev[fifo_cfg_pkg::sts_tx_space] = tx_free_blocks_i > cur_ff.tx_space_lvl;
        ev[fifo_cfg_pkg::sts_tx_level] = tx_status_used_i > cur_ff.tx_stat_lvl;
        ev[fifo_cfg_pkg::sts_rx_level] = rx_status_used_i > cur_ff.rx_stat_lvl;
        if (pop && cur_ff.countdown != '0) begin
            nxt_ff.countdown = cur_ff.countdown - 1'b1;
            if (cur_ff.countdown == cnt_w'(1) && cur_ff.armed) begin
                ev[fifo_cfg_pkg::sts_rx_dma] = 1'b1;
                nxt_ff.armed = 1'b0;
            end
        end
        nxt_ff.rdata = 32'h0;
        nxt_ff.port_rd = rd_data;
        if (rd_i) begin
            if (hit(fifo_cfg_pkg::probe_ofs)) begin
                nxt_ff.rdata = fifo_cfg_pkg::probe_value;
            end else if (hit(fifo_cfg_pkg::thresh_ofs)) begin
                nxt_ff.rdata = {cur_ff.tx_space_lvl, cur_ff.tx_stat_lvl, 8'h0,
                                cur_ff.rx_stat_lvl};
            end else if (hit(fifo_cfg_pkg::rxcfg_ofs)) begin
                nxt_ff.rdata = {cur_ff.align, 2'b00, cur_ff.countdown, 3'b000,
                                cur_ff.offset, 8'h0};
            end else if (hit(fifo_cfg_pkg::int_sts_ofs)) begin
                nxt_ff.rdata = cur_ff.sts;
                nxt_ff.sts = 32'h0;
            end else if (hit(fifo_cfg_pkg::int_en_ofs)) begin
                nxt_ff.rdata = cur_ff.en;
            end
        end
        if (wr_i) begin
            if (hit(fifo_cfg_pkg::probe_ofs)) begin
                nxt_ff.wake = sleeping_i;
            end else if (hit(fifo_cfg_pkg::thresh_ofs)) begin
                nxt_ff.tx_space_lvl = wdata_i[fifo_cfg_pkg::tx_space_lsb +: 8];
                nxt_ff.tx_stat_lvl = wdata_i[fifo_cfg_pkg::tx_stat_lsb +: 8];
                nxt_ff.rx_stat_lvl = wdata_i[fifo_cfg_pkg::rx_stat_lsb +: 8];
            end else if (hit(fifo_cfg_pkg::rxcfg_ofs)) begin
                nxt_ff.align = wdata_i[fifo_cfg_pkg::align_lsb +: 2];
                nxt_ff.countdown = wdata_i[fifo_cfg_pkg::countdown_lsb +: cnt_w];
                nxt_ff.armed = wdata_i[fifo_cfg_pkg::countdown_lsb +: cnt_w] != '0;
                nxt_ff.offset = wdata_i[fifo_cfg_pkg::offset_lsb +: 5];
                nxt_ff.flush = wdata_i[fifo_cfg_pkg::flush_bit];
            end else if (hit(fifo_cfg_pkg::int_en_ofs)) begin
                nxt_ff.en = wdata_i & fifo_cfg_pkg::sts_mask;
            end
        end
        nxt_ff.sts = nxt_ff.sts | (ev & fifo_cfg_pkg::sts_mask);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cur_ff <= '0;
            cur_ff.tx_space_lvl <= fifo_cfg_pkg::tx_space_rst;
            cur_ff.tx_stat_lvl <= fifo_cfg_pkg::tx_stat_rst;
            cur_ff.rx_stat_lvl <= fifo_cfg_pkg::rx_stat_rst;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // The formatter registers a read port word on the read edge itself.
    assign rdata_o = cur_ff.port_rd ? fmt_data : cur_ff.rdata;
    assign rx_fifo_pop_o = pop;
    assign rx_flush_o = cur_ff.flush;
    assign wake_o = cur_ff.wake;
    assign irq_o = |(cur_ff.sts & cur_ff.en);
endmodule // fifo_level_config

// *** rtl/rx_read_formatter.sv ***
`timescale 1ns/1ps
// Formats RX data reads: start offset bytes ahead, pad DWORDs after.
module rx_read_formatter #(
    parameter int dw_cnt_w = 12
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic read_i,
    input wire logic [1:0] align_i,
    input wire logic [4:0] offset_i,
    input wire logic [dw_cnt_w-1:0] pkt_dwords_i,
    input wire logic [31:0] fifo_data_i,
    output logic fifo_pop_o,
    output logic [31:0] data_o,
    output logic last_o
);
    typedef struct packed {
        logic [dw_cnt_w-1:0] pos;
        logic [dw_cnt_w-1:0] total;
        logic [31:0] data;
        logic last;
    } fmt_t;
    fmt_t cur_ff;
    fmt_t nxt_ff;
    logic [dw_cnt_w-1:0] lead;
    logic [dw_cnt_w-1:0] body_end;
    logic [dw_cnt_w-1:0] aligned_end;
    logic [dw_cnt_w-1:0] amask;

    always_comb begin
        lead = dw_cnt_w'(offset_i[4:2]) + dw_cnt_w'(offset_i[1:0] != 2'b00);
        body_end = lead + pkt_dwords_i;
        unique case (align_i)
            2'b01: amask = dw_cnt_w'(3);
            2'b10: amask = dw_cnt_w'(7);
            default: amask = '0;
        endcase
        aligned_end = (body_end + amask) & ~amask;
        nxt_ff = cur_ff;
        fifo_pop_o = 1'b0;
        if (read_i) begin
            nxt_ff.data = 32'h0;
            if (cur_ff.pos >= lead && cur_ff.pos < body_end) begin
                fifo_pop_o = 1'b1;
                nxt_ff.data = fifo_data_i;
            end
            nxt_ff.last = (cur_ff.pos + 1'b1) >= aligned_end;
            nxt_ff.pos = nxt_ff.last ? '0 : cur_ff.pos + 1'b1;
            nxt_ff.total = aligned_end;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign data_o = cur_ff.data;
    assign last_o = cur_ff.last;
endmodule // rx_read_formatter

// *** verif/fifo_cfg_sva.sv ***
`timescale 1ns/1ps
module fifo_cfg_sva (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic sleeping_i,
    input wire logic rx_fifo_pop_o,
    input wire logic rx_flush_o,
    input wire logic wake_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    wire logic fw = wr_i && addr_i == 8'h6c && wdata_i[15];
    wire logic wk = wr_i && addr_i == 8'h64 && sleeping_i;
    probe_read_a: assert property (rd_i && addr_i == 8'h64 |=> rdata_o == 32'h87654321)
        else $error("probe read wrong");
    idle_read_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not idle");
    flush_pulse_a: assert property (fw |=> rx_flush_o)
        else $error("flush pulse missing");
    flush_cause_a: assert property (!fw |=> !rx_flush_o)
        else $error("flush without write");
    flush_readback_a: assert property (rd_i && addr_i == 8'h6c |=> !rdata_o[15])
        else $error("flush bit not cleared");
    wake_pulse_a: assert property (wk |=> wake_o)
        else $error("wake missing");
    wake_cause_a: assert property (!wk |=> !wake_o)
        else $error("wake without write");
    pop_read_a: assert property (rx_fifo_pop_o |-> rd_i && addr_i == 8'h00)
        else $error("pop outside read");
endmodule // fifo_cfg_sva
bind fifo_level_config fifo_cfg_sva chk (.core_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .sleeping_i, .rx_fifo_pop_o, .rx_flush_o, .wake_o);

// *** verif/host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model (
    input wire logic core_clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic last_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [31:0] wdata_o = 32'h0,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    // Configuration writes are issued only between packets.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
    endtask
    // Read data and the last flag are taken once, in the answer cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic l);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        #1;
        v = rdata_i;
        l = last_i;
    endtask
endmodule // host_bus_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic core_clk_i, srst_i, wr, rd, sleeping_i, pop, flush, wake, last, irq, l;
    logic [7:0] addr, txf, txs, rxs;
    logic [11:0] pk;
    logic [31:0] wdata, rdata, d;
    logic [31:0] fd = 32'h0a000000;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    fifo_level_config dut (.core_clk_i, .srst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .tx_free_blocks_i(txf), .tx_status_used_i(txs),
        .rx_status_used_i(rxs), .pkt_dwords_i(pk), .rx_fifo_data_i(fd), .sleeping_i,
        .rx_fifo_pop_o(pop), .rx_flush_o(flush), .wake_o(wake), .rx_last_o(last), .irq_o(irq));
    host_bus_model host (.core_clk_i, .rdata_i(rdata), .last_i(last), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (pop) fd <= fd + 32'h1;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, d, l);
        chk(d, e);
    endtask
    task automatic rx_pkt(input int lead, input int n, input int tot, input logic [31:0] b);
        for (int i = 0; i < tot; i++) begin
            host.rd(8'h00, d, l);
            chk(d, (i >= lead && i < lead + n) ? b + 32'(i - lead) : 32'h0);
            chk({31'h0, l}, {31'h0, i == tot - 1});
        end
    endtask
    task automatic t_probe();
        rdchk(8'h64, 32'h87654321);
        @(posedge core_clk_i);
        sleeping_i <= 1'b1;
        host.wr(8'h64, 32'h0);
        #1 chk({31'h0, wake}, 32'h1);
        @(posedge core_clk_i);
        sleeping_i <= 1'b0;
        rdchk(8'h64, 32'h87654321);
        rdchk(8'h70, 32'h0);
        $display("probe test done");
    endtask
    task automatic t_levels();
        rdchk(8'h68, 32'h48000000);
        host.wr(8'h5c, 32'h00000280);
        rdchk(8'h58, 32'h0);
        @(posedge core_clk_i);
        txf <= 8'h49;
        txs <= 8'h01;
        rxs <= 8'h01;
        repeat (2) @(posedge core_clk_i);
        rdchk(8'h58, 32'h00000288);
        chk({31'h0, irq}, 32'h1);
        @(posedge core_clk_i);
        txf <= 8'h48;
        txs <= 8'h00;
        rxs <= 8'h00;
        repeat (2) @(posedge core_clk_i);
        host.rd(8'h58, d, l);
        rdchk(8'h58, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("level test done");
    endtask
    task automatic t_rx();
        @(posedge core_clk_i);
        pk <= 12'h002;
        host.wr(8'h5c, 32'h00100000);
        host.wr(8'h6c, 32'h40050000);
        host.wr(8'h6c, 32'h40020000);
        rx_pkt(0, 2, 4, 32'h0a000000);
        chk({31'h0, irq}, 32'h1);
        rdchk(8'h58, 32'h00100000);
        @(posedge core_clk_i);
        pk <= 12'h001;
        host.wr(8'h6c, 32'h00000800);
        rx_pkt(2, 1, 3, 32'h0a000002);
        $display("read path test done");
    endtask
    task automatic t_flush();
        host.wr(8'h6c, 32'h00008000);
        #1 chk({31'h0, flush}, 32'h1);
        rdchk(8'h6c, 32'h0);
        $display("flush test done");
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        srst_i = 1'b1;
        sleeping_i = 1'b0;
        txf = 8'h48;
        txs = 8'h00;
        rxs = 8'h00;
        pk = 12'h0;
        repeat (6) @(posedge core_clk_i);
        srst_i <= 1'b0;
        t_probe();
        t_levels();
        t_rx();
        t_flush();
        give_verdict();
    end
endmodule // testbench
